/* File: alu_status_flag_logic.sv */
// Top of the ALU status flag block with addressing mode check and bus slave.
//
// Overview of operation
// RULE_01 - Overflow flag set when signed result sign bit 7 flips wrongly, else cleared.
// RULE_02 - Additions set digit carry on carry out of low nibble, else clear.
// RULE_03 - Subtraction adds the complement; carry and digit carry mean no borrow.
// RULE_04 - Rotates through carry load carry from the high or low source bit.
// RULE_05 - Program memory is addressed only by the program counter.
// RULE_06 - Most instructions use one fixed mode; some use up to three modes.
// RULE_07 - Indexed literal offset mode exists only while extended set enable is 1.
// RULE_08 - Enabling the extended set changes how some instructions execute.
// RULE_09 - Negative flag copies result MSB; zero flag set when result is zero.
// RULE_10 - Additions set carry on carry out of the MSB, else clear.
//
// The Wishbone slave port and the address map were left to the implementer.
`timescale 1ns/10ps
module alu_status_flag_logic
   import alu_flag_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_sys_rst,
   // Wishbone slave.
   input  wire logic              i_wb_cyc,
   input  wire logic              i_wb_stb,
   input  wire logic              i_wb_we,
   input  wire logic [BUS_AW-1:0] i_wb_adr,
   input  wire logic [3:0]        i_wb_sel,
   input  wire logic [31:0]       i_wb_dat,
   output logic      [31:0]       o_wb_dat,
   output logic                   o_wb_ack,
   // ALU operation.
   input  wire logic              i_alu_valid,
   input  wire alu_op_t           i_alu_op,
   input  wire logic [7:0]        i_alu_a,
   input  wire logic [7:0]        i_alu_b,
   output logic      [7:0]        o_alu_result,
   output logic      [7:0]        o_alu_flags,
   // Data addressing request.
   input  wire logic              i_mode_req,
   input  wire logic              i_mode_multi,
   input  wire addr_mode_t        i_mode_fixed,
   input  wire addr_mode_t        i_mode_sel,
   output addr_mode_t             o_mode_used,
   output logic                   o_mode_ok,
   output logic                   o_mode_fault,
   // Program fetch.
   input  wire logic              i_pc_step,
   input  wire logic              i_pc_load,
   input  wire logic [PC_W-1:0]   i_pc_value,
   output logic      [PC_W-1:0]   o_prog_addr,
   // Configuration pin.
   input  wire logic              i_extended_set_enable
);

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   logic [7:0]      flags_ff,  nxt_flags;
   logic [7:0]      result_ff, nxt_result;
   logic [7:0]      config_ff, nxt_config;
   logic [31:0]     rdata_ff,  nxt_rdata;
   logic            ack_ff,    nxt_ack;
   bus_state_t      bus_ff,    nxt_bus;
   addr_mode_t      mode_ff,   nxt_mode;
   logic            ok_ff,     nxt_ok;
   logic            fault_ff,  nxt_fault;
   logic [PC_W-1:0] pc_ff,     nxt_pc;
   logic            ext_meta_ff;
   logic            ext_sync_ff;

   alu_flag_if calc_if ();

   alu_flag_calc u_calc (
      .port_if (calc_if.calc)
   );

   assign calc_if.op       = i_alu_op;
   assign calc_if.opa      = i_alu_a;
   assign calc_if.opb      = i_alu_b;
   assign calc_if.carry_in = flags_ff[FLAG_C_BIT];

   // -------------------------------------------------------------------------
   // Configuration pin synchroniser
   // -------------------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         ext_meta_ff <= 1'b0;
         ext_sync_ff <= 1'b0;
      end else begin
         ext_meta_ff <= i_extended_set_enable;
         ext_sync_ff <= ext_meta_ff;
      end
   end

   // -------------------------------------------------------------------------
   // Bus decode
   // -------------------------------------------------------------------------
   logic bus_hit;
   logic bus_wr;
   assign bus_hit = i_wb_cyc && i_wb_stb && (bus_ff == BUS_IDLE);
   assign bus_wr  = bus_hit && i_wb_we && i_wb_sel[0];

   always_comb begin
      nxt_bus   = BUS_IDLE;
      nxt_ack   = 1'b0;
      nxt_rdata = rdata_ff;
      case (bus_ff)
         BUS_IDLE: begin
            if (bus_hit) begin
               nxt_bus   = BUS_ACK;
               nxt_ack   = 1'b1;
               nxt_rdata = 32'h0000_0000;
               case (i_wb_adr)
                  REG_FLAGS_OFS:  nxt_rdata[7:0] = flags_ff & FLAG_IMPL_MASK;
                  REG_CONFIG_OFS: nxt_rdata[7:0] = config_ff;
                  REG_STATE_OFS:  nxt_rdata[7:0] = {result_ff};
                  default:        nxt_rdata = 32'h0000_0000;
               endcase
               if (i_wb_adr == REG_STATE_OFS) begin
                  nxt_rdata[15:8]  = {3'h0, ext_sync_ff, fault_ff, mode_ff};
               end
            end
         end
         // The ack falls here for one cycle, so a request still held is answered again every second cycle.
         BUS_ACK: nxt_bus = BUS_IDLE;
         default: nxt_bus = BUS_IDLE;
      endcase
   end

   // -------------------------------------------------------------------------
   // Flags, result and configuration
   // -------------------------------------------------------------------------
   always_comb begin
      nxt_flags  = flags_ff;
      nxt_result = result_ff;
      nxt_config = config_ff;
      if (bus_wr && (i_wb_adr == REG_FLAGS_OFS)) begin
         nxt_flags = i_wb_dat[7:0] & FLAG_IMPL_MASK;
      end
      if (bus_wr && (i_wb_adr == REG_CONFIG_OFS)) begin
         nxt_config = i_wb_dat[7:0];
      end
      // An ALU update in the same cycle as a software write wins on its own bits.
      if (i_alu_valid) begin
         nxt_result = calc_if.result;
         nxt_flags  = (nxt_flags & ~calc_if.affect) |
                      (calc_if.flags & calc_if.affect); // [RULE_01] [RULE_02] [RULE_09] [RULE_10]
      end
   end

   // -------------------------------------------------------------------------
   // Data addressing mode resolution
   // -------------------------------------------------------------------------
   always_comb begin
      addr_mode_t want;
      logic       legal;
      want      = i_mode_multi ? i_mode_sel : i_mode_fixed; // [RULE_06]
      legal     = 1'b0;
      nxt_mode  = mode_ff;
      nxt_ok    = 1'b0;
      nxt_fault = 1'b0;
      // With the extended set on, direct requests of multi-mode instructions
      // run as indexed unless software forces the plain direct behaviour.
      if (ext_sync_ff && i_mode_multi && (want == MODE_DIRECT) &&
          !config_ff[CFG_DIRECT_BIT]) begin
         want = MODE_INDEXED; // [RULE_08]
      end
      case (want)
         MODE_INHERENT: legal = !i_mode_multi;
         MODE_LITERAL:  legal = !i_mode_multi;
         // Multi-mode instructions choose among at most these three modes.
         MODE_DIRECT:   legal = 1'b1; // [RULE_06]
         MODE_INDIRECT: legal = 1'b1; // [RULE_06]
         MODE_INDEXED:  legal = ext_sync_ff; // [RULE_07]
         default:       legal = 1'b0;
      endcase
      if (i_mode_req) begin
         nxt_mode  = legal ? want : mode_ff;
         nxt_ok    = legal;
         nxt_fault = !legal; // [RULE_07]
      end
   end

   // -------------------------------------------------------------------------
   // Program counter
   // -------------------------------------------------------------------------
   always_comb begin
      nxt_pc = pc_ff;
      // The program counter is the only source of program memory addresses.
      if (i_pc_load) begin
         nxt_pc = i_pc_value; // [RULE_05]
      end else if (i_pc_step) begin
         nxt_pc = pc_ff + PC_STEP; // [RULE_05]
      end
   end

   // -------------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         flags_ff  <= FLAGS_RESET;
         result_ff <= ZERO_BYTE;
         config_ff <= CONFIG_RESET;
         rdata_ff  <= 32'h0000_0000;
         ack_ff    <= 1'b0;
         bus_ff    <= BUS_IDLE;
         mode_ff   <= MODE_INHERENT;
         ok_ff     <= 1'b0;
         fault_ff  <= 1'b0;
         pc_ff     <= PC_RESET;
      end else begin
         flags_ff  <= nxt_flags;
         result_ff <= nxt_result;
         config_ff <= nxt_config;
         rdata_ff  <= nxt_rdata;
         ack_ff    <= nxt_ack;
         bus_ff    <= nxt_bus;
         mode_ff   <= nxt_mode;
         ok_ff     <= nxt_ok;
         fault_ff  <= nxt_fault;
         pc_ff     <= nxt_pc;
      end
   end

   assign o_wb_dat     = rdata_ff;
   assign o_wb_ack     = ack_ff;
   assign o_alu_result = result_ff;
   assign o_alu_flags  = flags_ff;
   assign o_mode_used  = mode_ff;
   assign o_mode_ok    = ok_ff;
   assign o_mode_fault = fault_ff;
   assign o_prog_addr  = pc_ff;

endmodule // alu_status_flag_logic

/* File: alu_flag_pkg.sv */
// Shared constants, field layouts and enumerations for the ALU status flag block.
package alu_flag_pkg;

   // -------------------------------------------------------------------------
   // Register map (byte addresses on the 32-bit bus)
   // -------------------------------------------------------------------------
   localparam logic [7:0] REG_FLAGS_OFS   = 8'h00;
   localparam logic [7:0] REG_CONFIG_OFS  = 8'h04;
   localparam logic [7:0] REG_STATE_OFS   = 8'h08;
   localparam int         BUS_AW          = 8;

   // -------------------------------------------------------------------------
   // Flag register fields
   // -------------------------------------------------------------------------
   localparam int         FLAG_C_BIT      = 0;
   localparam int         FLAG_DC_BIT     = 1;
   localparam int         FLAG_Z_BIT      = 2;
   localparam int         FLAG_OV_BIT     = 3;
   localparam int         FLAG_N_BIT      = 4;
   localparam logic [7:0] FLAG_IMPL_MASK  = 8'h1F;
   localparam logic [7:0] FLAGS_RESET     = 8'h00;

   // -------------------------------------------------------------------------
   // Data path widths and bit positions
   // -------------------------------------------------------------------------
   localparam int         DATA_W          = 8;
   localparam int         SIGN_BIT        = 7;
   localparam int         NIBBLE_W        = 4;
   localparam logic [7:0] ZERO_BYTE       = 8'h00;
   localparam logic [7:0] CONFIG_RESET    = 8'h00;
   localparam int         CFG_DIRECT_BIT  = 0;
   localparam int         PC_W            = 16;
   localparam logic [15:0] PC_RESET       = 16'h0000;
   localparam logic [15:0] PC_STEP        = 16'h0001;

   // -------------------------------------------------------------------------
   // Operations and addressing modes
   // -------------------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_ADD  = 4'h0,
      OP_ADDC = 4'h1,
      OP_SUB  = 4'h2,
      OP_SUBB = 4'h3,
      OP_AND  = 4'h4,
      OP_IOR  = 4'h5,
      OP_XOR  = 4'h6,
      OP_RLC  = 4'h7,
      OP_RRC  = 4'h8,
      OP_MOV  = 4'h9
   } alu_op_t;

   typedef enum logic [2:0] {
      MODE_INHERENT = 3'h0,
      MODE_LITERAL  = 3'h1,
      MODE_DIRECT   = 3'h2,
      MODE_INDIRECT = 3'h3,
      MODE_INDEXED  = 3'h4
   } addr_mode_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'h0,
      BUS_ACK  = 2'h1
   } bus_state_t;

endpackage

/* File: alu_flag_if.sv */
// Interface carrying one ALU operation and its computed flags between modules.
`timescale 1ns/10ps
interface alu_flag_if;
   import alu_flag_pkg::*;
   alu_op_t    op;
   logic [7:0] opa;
   logic [7:0] opb;
   logic       carry_in;
   logic [7:0] result;
   logic [7:0] flags;
   logic [7:0] affect;

   modport calc (
      input  op,
      input  opa,
      input  opb,
      input  carry_in,
      output result,
      output flags,
      output affect
   );
   modport user (
      output op,
      output opa,
      output opb,
      output carry_in,
      input  result,
      input  flags,
      input  affect
   );
endinterface

/* File: alu_flag_calc.sv */
// Combinational ALU result and status flag computation.
`timescale 1ns/10ps
module alu_flag_calc
   import alu_flag_pkg::*;
(
   alu_flag_if.calc port_if
);

   // -------------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------------
   function automatic logic [8:0] add9(input logic [7:0] x,
                                       input logic [7:0] y,
                                       input logic       cin);
      add9 = {1'b0, x} + {1'b0, y} + {8'h00, cin};
   endfunction

   function automatic logic [4:0] add5(input logic [7:0] x,
                                       input logic [7:0] y,
                                       input logic       cin);
      add5 = {1'b0, x[NIBBLE_W-1:0]} + {1'b0, y[NIBBLE_W-1:0]} + {4'h0, cin};
   endfunction

   // -------------------------------------------------------------------------
   // Datapath
   // -------------------------------------------------------------------------
   always_comb begin
      logic [7:0] addend;
      logic       cin;
      logic [8:0] sum;
      logic [4:0] low;
      logic       arith;
      addend = port_if.opb;
      sum    = 9'h000;
      low    = 5'h00;
      cin    = 1'b0;
      arith  = 1'b0;
      case (port_if.op)
         OP_ADD:  begin arith = 1'b1; end
         OP_ADDC: begin arith = 1'b1; cin = port_if.carry_in; end
         // Subtraction adds the complement, so C and DC read as not-borrow.
         OP_SUB:  begin arith = 1'b1; addend = ~port_if.opb; cin = 1'b1; end // [RULE_03]
         OP_SUBB: begin arith = 1'b1; addend = ~port_if.opb; cin = port_if.carry_in; end // [RULE_03]
         default: begin arith = 1'b0; end
      endcase
      sum = add9(port_if.opa, addend, cin);
      low = add5(port_if.opa, addend, cin);
      port_if.flags  = ZERO_BYTE;
      port_if.affect = ZERO_BYTE;
      port_if.affect[FLAG_Z_BIT] = 1'b1;
      port_if.affect[FLAG_N_BIT] = 1'b1;
      case (port_if.op)
         OP_AND:  port_if.result = port_if.opa & port_if.opb;
         OP_IOR:  port_if.result = port_if.opa | port_if.opb;
         OP_XOR:  port_if.result = port_if.opa ^ port_if.opb;
         OP_MOV:  port_if.result = port_if.opa;
         OP_RLC: begin
            port_if.result = {port_if.opa[SIGN_BIT-1:0], port_if.carry_in};
            port_if.flags[FLAG_C_BIT]  = port_if.opa[SIGN_BIT]; // [RULE_04]
            port_if.affect[FLAG_C_BIT] = 1'b1;
         end
         OP_RRC: begin
            port_if.result = {port_if.carry_in, port_if.opa[SIGN_BIT:1]};
            port_if.flags[FLAG_C_BIT]  = port_if.opa[0]; // [RULE_04]
            port_if.affect[FLAG_C_BIT] = 1'b1;
         end
         default: port_if.result = sum[DATA_W-1:0];
      endcase
      if (arith) begin
         port_if.affect = FLAG_IMPL_MASK;
         port_if.flags[FLAG_C_BIT]  = sum[DATA_W]; // [RULE_10]
         port_if.flags[FLAG_DC_BIT] = low[NIBBLE_W]; // [RULE_02]
         // Signed overflow: like-signed operands giving a result of the other sign.
         port_if.flags[FLAG_OV_BIT] = (port_if.opa[SIGN_BIT] == addend[SIGN_BIT]) &&
                                      (sum[SIGN_BIT] != port_if.opa[SIGN_BIT]); // [RULE_01]
      end
      port_if.flags[FLAG_N_BIT] = port_if.result[SIGN_BIT]; // [RULE_09]
      port_if.flags[FLAG_Z_BIT] = (port_if.result == ZERO_BYTE); // [RULE_09]
   end

endmodule // alu_flag_calc

/* File: alu_status_flag_logic_sva.sv */
// Concurrent checks on the ports of the ALU status flag block.
`timescale 1ns/10ps
module alu_status_flag_logic_sva
   import alu_flag_pkg::*;
(
   input wire logic              i_clk,
   input wire logic              i_sys_rst,
   input wire logic              i_wb_cyc,
   input wire logic              i_wb_stb,
   input wire logic              o_wb_ack,
   input wire logic              i_alu_valid,
   input wire alu_op_t           i_alu_op,
   input wire logic [7:0]        i_alu_a,
   input wire logic [7:0]        i_alu_b,
   input wire logic [7:0]        o_alu_result,
   input wire logic [7:0]        o_alu_flags,
   input wire logic              i_mode_req,
   input wire logic              i_mode_multi,
   input wire addr_mode_t        i_mode_fixed,
   input wire addr_mode_t        i_mode_sel,
   input wire addr_mode_t        o_mode_used,
   input wire logic              o_mode_ok,
   input wire logic              o_mode_fault,
   input wire logic              i_pc_step,
   input wire logic              i_pc_load,
   input wire logic [PC_W-1:0]   i_pc_value,
   input wire logic [PC_W-1:0]   o_prog_addr,
   input wire logic              i_extended_set_enable
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   ack_timing_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack && !$past(o_wb_ack)
      |=> o_wb_ack ##1 !o_wb_ack) else $error("bus ack not a single pulse");
   add_carry_a: assert property (i_alu_valid && i_alu_op == OP_ADD |=>
      {o_alu_flags[FLAG_C_BIT], o_alu_result} == {1'b0, $past(i_alu_a)} + $past(i_alu_b))
      else $error("add carry or sum wrong");
   digit_carry_a: assert property (i_alu_valid && i_alu_op == OP_ADD |=>
      o_alu_flags[FLAG_DC_BIT] == ($past(i_alu_a[3:0]) + {1'b0, $past(i_alu_b[3:0])} > 5'h0F))
      else $error("digit carry wrong");
   overflow_a: assert property (i_alu_valid && i_alu_op == OP_ADD |=>
      o_alu_flags[FLAG_OV_BIT] == ($past(i_alu_a[7]) == $past(i_alu_b[7])
      && o_alu_result[7] != $past(i_alu_a[7]))) else $error("overflow flag wrong");
   sub_borrow_a: assert property (i_alu_valid && i_alu_op == OP_SUB |=>
      o_alu_flags[FLAG_C_BIT] == ($past(i_alu_a) >= $past(i_alu_b))) else $error("borrow wrong");
   rotate_carry_a: assert property (i_alu_valid && i_alu_op == OP_RLC |=>
      o_alu_flags[FLAG_C_BIT] == $past(i_alu_a[7])) else $error("rotate carry wrong");
   rotate_right_a: assert property (i_alu_valid && i_alu_op == OP_RRC |=>
      o_alu_flags[FLAG_C_BIT] == $past(i_alu_a[0])) else $error("right rotate carry wrong");
   sign_zero_a: assert property (i_alu_valid |=>
      o_alu_flags[FLAG_N_BIT] == o_alu_result[7]
      && o_alu_flags[FLAG_Z_BIT] == (o_alu_result == ZERO_BYTE)) else $error("N or Z wrong");
   pc_load_a: assert property (i_pc_load |=> o_prog_addr == $past(i_pc_value))
      else $error("program address not loaded");
   pc_step_a: assert property (i_pc_step && !i_pc_load |=>
      o_prog_addr == $past(o_prog_addr) + PC_STEP) else $error("program address not stepped");
   fixed_mode_a: assert property (i_mode_req && !i_mode_multi
      && i_mode_fixed == MODE_DIRECT
      |=> o_mode_ok && o_mode_used == MODE_DIRECT) else $error("fixed mode refused");
   indexed_gate_a: assert property (i_mode_req && i_mode_multi
      && i_mode_sel == MODE_INDEXED
      && !i_extended_set_enable && !$past(i_extended_set_enable) && !$past(i_extended_set_enable, 2)
      |=> o_mode_fault && !o_mode_ok) else $error("indexed mode allowed while disabled");
endmodule // alu_status_flag_logic_sva

bind alu_status_flag_logic alu_status_flag_logic_sva u_sva (.*);

/* File: alu_status_flag_logic_test.sv */
// Self-checking testbench for the ALU status flag block.
`timescale 1ns/10ps
module alu_status_flag_logic_test
   import alu_flag_pkg::*;
;
   logic i_clk = 0, i_sys_rst = 1, cyc = 0, stb = 0, we = 0, vld = 0, mreq = 0, multi = 0;
   logic pcs = 0, pcl = 0, ext = 0, o_wb_ack, o_mode_ok, o_mode_fault;
   logic [3:0] sel = 4'h0;
   logic [7:0] adr = 8'h00, opa = 8'h00, opb = 8'h00, o_alu_result, o_alu_flags;
   logic [15:0] pcv = 16'h0000, o_prog_addr;
   logic [31:0] wdat = 32'h0, o_wb_dat, q;
   alu_op_t aop = OP_ADD;
   addr_mode_t mfix = MODE_INHERENT, msel = MODE_INHERENT, o_mode_used;
   int err_count = 0, check_count = 0;

   alu_status_flag_logic dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
      .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_alu_valid(vld), .i_alu_op(aop),
      .i_alu_a(opa), .i_alu_b(opb), .o_alu_result(o_alu_result), .o_alu_flags(o_alu_flags),
      .i_mode_req(mreq), .i_mode_multi(multi), .i_mode_fixed(mfix), .i_mode_sel(msel),
      .o_mode_used(o_mode_used), .o_mode_ok(o_mode_ok), .o_mode_fault(o_mode_fault),
      .i_pc_step(pcs), .i_pc_load(pcl), .i_pc_value(pcv), .o_prog_addr(o_prog_addr),
      .i_extended_set_enable(ext));

   always #5 i_clk = ~i_clk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Holds the request until ack is sampled, for at most 50 cycles, then counts a missing answer as an error.
   task automatic wb(input logic w, input logic [3:0] s, input logic [7:0] a,
                     input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clk);
      cyc <= 1; stb <= 1; we <= w; sel <= s; adr <= a; wdat <= d;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_wb_ack !== 1'b1 && n < 50);
      q = o_wb_dat;
      cyc <= 0; stb <= 0;
      chk(n < 50, 1);
   endtask

   task automatic alu(input alu_op_t op, input logic [7:0] a, b, er, ef);
      @(posedge i_clk);
      vld <= 1; aop <= op; opa <= a; opb <= b;
      @(posedge i_clk);
      vld <= 0;
      @(posedge i_clk);
      chk(o_alu_result, er);
      chk(o_alu_flags, ef);
   endtask

   task automatic mode(input logic m, input addr_mode_t f, s, input logic ok,
                       input addr_mode_t u);
      @(posedge i_clk);
      mreq <= 1; multi <= m; mfix <= f; msel <= s;
      @(posedge i_clk);
      mreq <= 0;
      @(posedge i_clk);
      chk(o_mode_ok, ok);
      chk(o_mode_fault, !ok);
      if (ok) chk(o_mode_used, u);
   endtask

   task automatic regs_test;
      wb(0, 4'hF, REG_FLAGS_OFS, 0);   chk(q, FLAGS_RESET);
      wb(1, 4'hF, REG_FLAGS_OFS, 32'hFF);
      wb(0, 4'hF, REG_FLAGS_OFS, 0);   chk(q, FLAG_IMPL_MASK);
      wb(1, 4'h0, REG_FLAGS_OFS, 32'h0);
      chk(o_alu_flags, FLAG_IMPL_MASK);
      wb(0, 4'hF, 8'h0C, 0);           chk(q, 0);
   endtask

   // Bit order of the expected flags is N OV Z DC C from bit 4 down.
   task automatic alu_test;
      alu(OP_ADD, 8'hFF, 8'h01, 8'h00, 8'h07);
      alu(OP_ADD, 8'h7F, 8'h01, 8'h80, 8'h1A);
      alu(OP_SUB, 8'h05, 8'h05, 8'h00, 8'h07);
      alu(OP_SUB, 8'h00, 8'h01, 8'hFF, 8'h10);
      alu(OP_RLC, 8'h80, 8'h00, 8'h00, 8'h05);
      alu(OP_RRC, 8'h01, 8'h00, 8'h80, 8'h11);
      // A flag write taken at the same edge as an ALU op keeps only the unaffected bits.
      fork
         alu(OP_MOV, 8'h00, 8'h00, 8'h00, 8'h0F);
         wb(1, 4'hF, REG_FLAGS_OFS, 32'h1F);
      join
      alu(OP_ADDC, 8'h01, 8'h01, 8'h03, 8'h00);
      alu(OP_SUBB, 8'h05, 8'h02, 8'h02, 8'h03);
      alu(OP_IOR, 8'h80, 8'h01, 8'h81, 8'h13);
      alu(OP_XOR, 8'h5A, 8'h5A, 8'h00, 8'h07);
      alu(OP_MOV, 8'h80, 8'h00, 8'h80, 8'h13);
      alu(OP_AND, 8'hF0, 8'h0F, 8'h00, 8'h07);
   endtask

   task automatic mode_test;
      mode(1, MODE_INHERENT, MODE_INDEXED, 0, MODE_INHERENT);
      mode(0, MODE_LITERAL, MODE_INDEXED, 1, MODE_LITERAL);
      mode(1, MODE_LITERAL, MODE_INHERENT, 0, MODE_INHERENT);
      mode(1, MODE_LITERAL, MODE_DIRECT, 1, MODE_DIRECT);
      mode(1, MODE_LITERAL, MODE_INDIRECT, 1, MODE_INDIRECT);
      mode(0, MODE_DIRECT, MODE_INHERENT, 1, MODE_DIRECT);
      ext <= 1;
      repeat (4) @(posedge i_clk);
      mode(1, MODE_LITERAL, MODE_INDEXED, 1, MODE_INDEXED);
      mode(1, MODE_LITERAL, MODE_DIRECT, 1, MODE_INDEXED);
      wb(1, 4'hF, REG_CONFIG_OFS, 32'h1);
      wb(0, 4'hF, REG_CONFIG_OFS, 0);  chk(q, 32'h1);
      mode(1, MODE_LITERAL, MODE_DIRECT, 1, MODE_DIRECT);
      wb(0, 4'hF, REG_STATE_OFS, 0);   chk(q, 32'h1200);
   endtask

   task automatic pc_test;
      @(posedge i_clk);
      pcl <= 1; pcv <= 16'h1234;
      @(posedge i_clk);
      pcl <= 0; pcs <= 1;
      @(posedge i_clk);
      pcs <= 0;
      chk(o_prog_addr, 16'h1234);
      @(posedge i_clk);
      chk(o_prog_addr, 16'h1235);
   endtask

   task automatic stop_test;
      $display("checks=%0d mismatches=%0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      repeat (4) @(posedge i_clk);
      i_sys_rst <= 0;
      regs_test();
      alu_test();
      mode_test();
      pc_test();
      stop_test();
   end

   initial begin
      #100000;
      err_count++;
      stop_test();
   end
endmodule // alu_status_flag_logic_test
